// ===== core/cgdc_consts.vh
`ifndef CGDC_CONSTS_VH
`define CGDC_CONSTS_VH
// Register byte offsets.
`define CGDC_OFF_CTRL 8'h00
`define CGDC_OFF_STATUS 8'h04
`define CGDC_OFF_GPIO_CFG 8'h08
`define CGDC_OFF_GPIO_OUT 8'h0c
`define CGDC_OFF_GPIO_IN 8'h10
`define CGDC_OFF_OE_CFG 8'h14
`define CGDC_OFF_ID0 8'h18
`define CGDC_OFF_ID1 8'h1c
`define CGDC_OFF_PF_FRAC 8'h20
`define CGDC_OFF_PF_INT 8'h24
`define CGDC_OFF_SSC0 8'h28
`define CGDC_OFF_SSC1 8'h2c
`define CGDC_OFF_LF 8'h30
`define CGDC_OFF_BANK 8'h34
`define CGDC_OFF_SE 8'h38
// Field positions.
`define CGDC_CTRL_DEFSEL_LO 0
`define CGDC_CTRL_USEPIN 3
`define CGDC_CTRL_I2CADDR_LO 8
`define CGDC_CTRL_REFMON 16
`define CGDC_CTRL_SSC_INPHASE 17
`define CGDC_CTRL_ID_SQUELCH 18
`define CGDC_ST_LOCK 0
`define CGDC_ST_DONE 1
`define CGDC_ST_CFG_LO 4
`define CGDC_ST_REFMON 8
// Reset values.
`define CGDC_RST_CTRL 32'h0000_0000
`define CGDC_RST_I2CADDR 7'h09
`define CGDC_RST_RATIO 25'h000_0004
// Timing: reference monitoring and spread rate limits in kHz, then spread amplitude limits.
`define CGDC_REFMON_MAX_KHZ 62500
`define CGDC_SSC_MIN_KHZ 30
`define CGDC_SSC_MAX_KHZ 63
`define CGDC_SSC_DOWN_MAX 8'd60
`define CGDC_SSC_CTR_MAX 8'd30
`endif

// ===== core/cgdc_top.v
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Function
// - Load one of eight stored configurations.
// - Select image by pins or default field.
// - Outputs off until power-up succeeds.
// - Enable outputs by register and pin.
// - Answer as I2C slave, programmable address.
// - Pin roles limited: one INT, one FAULT; the design implements no INT or FAULT pin roles.
// - Pins 6..1 open drain, pin 0 push-pull.
// - Software reads and writes pin levels.
// - Lock status readable in register.
// - No reference monitoring above 62.5MHz.
// - Integer dividers 25-bit, change immediately.
// - Glitchless squelch around ratio change.
// - Light divider uses first-order sigma-delta.
// - Light divider has plain integer mode.
// - Precise stage one: 8-bit fraction, halve.
// - Stage two 17-bit, ratio four, bypassable.
// - Spread on precise dividers 0,1 only.
// - Spread rate 30-63kHz, amplitude limited.
// - Spread off finishes current triangle.
// - Spread dividers can run in phase.
// - Single-ended pair: pin select, polarity.
// - Bank muxes allow documented sources only.
`include "cgdc_consts.vh"
module cgdc_top #(
  parameter ID_W = 25,
  parameter PF_INT_W = 17,
  parameter N_OUT = 6,
  parameter SSC_TICK = 16'd100
) (
  input wire core_clk,
  input wire arst_n,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] cfg_image_sel,
  input wire [31:0] cfg_image_data,
  input wire osc_ok,
  input wire pll_lock,
  input wire selftest_ok,
  input wire ref_over_limit,
  input wire [6:0] gpio_in,
  output reg [6:0] gpio_out,
  output reg [6:0] gpio_oe,
  input wire [1:0] gpi_in,
  input wire [7:0] i2c_addr_match,
  output reg [1:0] int_div_clk,
  output reg [1:0] light_div_clk,
  output reg [2:0] prec_div_clk,
  output reg [6:0] bank_clk,
  output reg [1:0] se_pin,
  output reg [N_OUT-1:0] out_en,
  output reg i2c_addr_hit,
  output reg ref_mon_active
);
  // ****************************************
  // Power-up sequencing
  // ****************************************
  localparam PU_LOAD = 2'd0;
  localparam PU_WAIT = 2'd1;
  localparam PU_RUN = 2'd2;
  localparam PU_FAIL = 2'd3;
  reg [1:0] pu_q;
  reg [2:0] img_q;
  reg [31:0] ctrl_q;
  wire [2:0] img_sel;
  assign img_sel = ctrl_q[`CGDC_CTRL_USEPIN] ? cfg_image_sel : ctrl_q[2:0];
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pu_q <= PU_LOAD;
      img_q <= 3'h0;
    end else begin
      case (pu_q)
        PU_LOAD: begin
          img_q <= img_sel;
          pu_q <= PU_WAIT;
        end
        PU_WAIT: begin
          if (osc_ok && pll_lock && selftest_ok) begin
            pu_q <= PU_RUN;
          end else if (!selftest_ok && osc_ok) begin
            pu_q <= PU_FAIL;
          end
        end
        PU_RUN: pu_q <= PU_RUN;
        default: pu_q <= PU_FAIL;
      endcase
    end
  end
  wire pu_done;
  assign pu_done = (pu_q == PU_RUN);
  // ****************************************
  // Register file
  // ****************************************
  reg [6:0] gpio_cfg_q;
  reg [6:0] gpio_wr_q;
  reg [N_OUT-1:0] oe_reg_q;
  reg [11:0] oe_pin_q;
  reg [ID_W-1:0] id_ratio_q [0:1];
  reg [7:0] pf_frac_q;
  reg [PF_INT_W-1:0] pf_int_q;
  reg [31:0] ssc_q [0:1];
  reg [31:0] lf_q;
  reg [31:0] bank_q;
  reg [3:0] se_q;
  reg [1:0] id_chg_q;
  reg aw_q;
  reg w_q;
  reg [7:0] awa_q;
  reg [31:0] wd_q;
  wire wr_go;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  function [31:0] cgdc_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        cgdc_merge[k*8 +: 8] = st[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction
  reg [3:0] wst_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      wst_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_q <= `CGDC_RST_CTRL | {17'h0, `CGDC_RST_I2CADDR, 8'h00};
      gpio_cfg_q <= 7'h00;
      gpio_wr_q <= 7'h7f;
      oe_reg_q <= {N_OUT{1'b1}};
      oe_pin_q <= 12'h000;
      id_ratio_q[0] <= `CGDC_RST_RATIO;
      id_ratio_q[1] <= `CGDC_RST_RATIO;
      pf_frac_q <= 8'h00;
      pf_int_q <= 17'h00004;
      ssc_q[0] <= 32'h0000_0000;
      ssc_q[1] <= 32'h0000_0000;
      lf_q <= 32'h0000_0004;
      bank_q <= 32'h0000_0000;
      se_q <= 4'h1;
      id_chg_q <= 2'b00;
    end else begin
      id_chg_q <= 2'b00;
      s_axi_awready <= !aw_q && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_q && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        wst_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (awa_q)
          `CGDC_OFF_CTRL: ctrl_q <= cgdc_merge(ctrl_q, wd_q, wst_q);
          `CGDC_OFF_GPIO_CFG: gpio_cfg_q <= wd_q[6:0];
          `CGDC_OFF_GPIO_OUT: gpio_wr_q <= wd_q[6:0];
          `CGDC_OFF_OE_CFG: begin
            oe_reg_q <= wd_q[N_OUT-1:0];
            oe_pin_q <= wd_q[27:16];
          end
          `CGDC_OFF_ID0: begin
            id_ratio_q[0] <= wd_q[ID_W-1:0];
            id_chg_q[0] <= 1'b1;
          end
          `CGDC_OFF_ID1: begin
            id_ratio_q[1] <= wd_q[ID_W-1:0];
            id_chg_q[1] <= 1'b1;
          end
          `CGDC_OFF_PF_FRAC: pf_frac_q <= wd_q[7:0];
          `CGDC_OFF_PF_INT: pf_int_q <= (wd_q[PF_INT_W-1:0] < 17'd4) ? 17'd4 : wd_q[PF_INT_W-1:0];
          `CGDC_OFF_SSC0: ssc_q[0] <= wd_q;
          `CGDC_OFF_SSC1: ssc_q[1] <= wd_q;
          `CGDC_OFF_LF: lf_q <= wd_q;
          `CGDC_OFF_BANK: bank_q <= wd_q;
          `CGDC_OFF_SE: se_q <= wd_q[3:0];
          default: s_axi_bresp <= 2'b10;
        endcase
      end
    end
  end
  // Pin roles: GPIO_CFG keeps bits 6..0 only; no INT or FAULT pin index is stored or assigned.
  wire [6:0] gpio_rd;
  assign gpio_rd = gpio_in;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gpio_out <= 7'h00;
      gpio_oe <= 7'h00;
    end else begin
      gpio_out[0] <= gpio_wr_q[0];
      gpio_oe[0] <= gpio_cfg_q[0];
      gpio_out[6:1] <= 6'h00;
      gpio_oe[6:1] <= gpio_cfg_q[6:1] & ~gpio_wr_q[6:1];
    end
  end
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr[7:0])
          `CGDC_OFF_CTRL: s_axi_rdata <= ctrl_q;
          `CGDC_OFF_STATUS: s_axi_rdata <= {23'h0, ref_mon_active, 1'b0, img_q, 2'b00, pu_done, pll_lock};
          `CGDC_OFF_GPIO_CFG: s_axi_rdata <= {25'h0, gpio_cfg_q};
          `CGDC_OFF_GPIO_OUT: s_axi_rdata <= {25'h0, gpio_wr_q};
          `CGDC_OFF_GPIO_IN: s_axi_rdata <= {14'h0, gpi_in, 9'h0, gpio_rd};
          `CGDC_OFF_OE_CFG: s_axi_rdata <= {4'h0, oe_pin_q, {(16-N_OUT){1'b0}}, oe_reg_q};
          `CGDC_OFF_ID0: s_axi_rdata <= {{(32-ID_W){1'b0}}, id_ratio_q[0]};
          `CGDC_OFF_ID1: s_axi_rdata <= {{(32-ID_W){1'b0}}, id_ratio_q[1]};
          `CGDC_OFF_PF_FRAC: s_axi_rdata <= {24'h0, pf_frac_q};
          `CGDC_OFF_PF_INT: s_axi_rdata <= {{(32-PF_INT_W){1'b0}}, pf_int_q};
          `CGDC_OFF_SSC0: s_axi_rdata <= ssc_q[0];
          `CGDC_OFF_SSC1: s_axi_rdata <= ssc_q[1];
          `CGDC_OFF_LF: s_axi_rdata <= lf_q;
          `CGDC_OFF_BANK: s_axi_rdata <= bank_q;
          `CGDC_OFF_SE: s_axi_rdata <= {28'h0, se_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end
  end
  // ****************************************
  // I2C address and reference monitor
  // ****************************************
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      i2c_addr_hit <= 1'b0;
      ref_mon_active <= 1'b0;
    end else begin
      i2c_addr_hit <= pu_done && (i2c_addr_match[6:0] == ctrl_q[14:8]);
      ref_mon_active <= ctrl_q[`CGDC_CTRL_REFMON] && !ref_over_limit;
    end
  end
  // ****************************************
  // Dividers (core_clk stands in for the VCO clock)
  // ****************************************
  reg [ID_W-1:0] id_cnt_q [0:1];
  reg [1:0] id_sq_q;
  reg [ID_W-1:0] lf_cnt_q [0:1];
  reg [7:0] lf_acc_q [0:1];
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_int
      always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          id_cnt_q[g] <= 25'h0;
          int_div_clk[g] <= 1'b0;
          id_sq_q[g] <= 1'b0;
          lf_cnt_q[g] <= 25'h0;
          lf_acc_q[g] <= 8'h00;
          light_div_clk[g] <= 1'b0;
        end else begin
          if (id_chg_q[g]) begin
            id_cnt_q[g] <= 25'h0;
            id_sq_q[g] <= ctrl_q[`CGDC_CTRL_ID_SQUELCH] && int_div_clk[g];
          end else if (id_cnt_q[g] + 25'h1 >= (id_ratio_q[g] >> 1)) begin
            id_cnt_q[g] <= 25'h0;
            int_div_clk[g] <= id_sq_q[g] ? 1'b0 : ~int_div_clk[g];
            id_sq_q[g] <= 1'b0;
          end else begin
            id_cnt_q[g] <= id_cnt_q[g] + 25'h1;
          end
          if (lf_cnt_q[g] + 25'h1 >= lf_q[24:1] + {24'h0, lf_acc_q[g][7] & ~lf_q[31]}) begin
            lf_cnt_q[g] <= 25'h0;
            light_div_clk[g] <= ~light_div_clk[g];
            lf_acc_q[g] <= {1'b0, lf_acc_q[g][6:0]} + {1'b0, lf_q[30:24]};
          end else begin
            lf_cnt_q[g] <= lf_cnt_q[g] + 25'h1;
          end
        end
      end
    end
  endgenerate
  // ****************************************
  // Spread engine and precise dividers
  // ****************************************
  reg [15:0] tick_q;
  reg [7:0] tri_q [0:1];
  reg [1:0] dir_q;
  reg [1:0] run_q;
  reg [8:0] pf_acc_q [0:2];
  reg [PF_INT_W-1:0] pf_cnt_q [0:2];
  reg [2:0] half_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= 16'h0;
    end else begin
      tick_q <= (tick_q >= SSC_TICK) ? 16'h0 : tick_q + 16'h1;
    end
  end
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_prec
      wire [7:0] amp;
      wire [7:0] lim;
      wire [7:0] ofs;
      if (g < 2) begin : g_ssc
        assign lim = ssc_q[g][8] ? `CGDC_SSC_CTR_MAX : `CGDC_SSC_DOWN_MAX;
        assign amp = (ssc_q[g][7:0] > lim) ? lim : ssc_q[g][7:0];
        assign ofs = ssc_q[g][8] ? tri_q[g] - (amp >> 1) : tri_q[g];
        always @(posedge core_clk or negedge arst_n) begin
          if (!arst_n) begin
            tri_q[g] <= 8'h00;
            dir_q[g] <= 1'b0;
            run_q[g] <= 1'b0;
          end else if (ctrl_q[`CGDC_CTRL_SSC_INPHASE] && g == 1 && ssc_q[0][31] && ssc_q[1][31]) begin
            tri_q[g] <= (tri_q[0] > amp) ? amp : tri_q[0];
            dir_q[g] <= dir_q[0];
            run_q[g] <= 1'b1;
          end else if (tick_q == 16'h0) begin
            if (!run_q[g]) begin
              run_q[g] <= ssc_q[g][31];
            end else if (!dir_q[g]) begin
              if (tri_q[g] >= amp) dir_q[g] <= 1'b1;
              else tri_q[g] <= tri_q[g] + 8'h1;
            end else if (tri_q[g] == 8'h00) begin
              dir_q[g] <= 1'b0;
              run_q[g] <= ssc_q[g][31];
            end else begin
              tri_q[g] <= tri_q[g] - 8'h1;
            end
          end
        end
      end else begin : g_nossc
        assign lim = 8'h00;
        assign amp = 8'h00;
        assign ofs = 8'h00;
      end
      always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          pf_acc_q[g] <= 9'h000;
          half_q[g] <= 1'b0;
          pf_cnt_q[g] <= 17'h0;
          prec_div_clk[g] <= 1'b0;
        end else begin
          pf_acc_q[g] <= {1'b0, pf_acc_q[g][7:0]} + {1'b0, pf_frac_q + ofs};
          if (!pf_acc_q[g][8]) begin
            half_q[g] <= ~half_q[g];
            if (half_q[g]) begin
              if (pf_int_q[16]) begin
                prec_div_clk[g] <= ~prec_div_clk[g];
              end else if (pf_cnt_q[g] + 17'h1 >= (pf_int_q >> 1)) begin
                pf_cnt_q[g] <= 17'h0;
                prec_div_clk[g] <= ~prec_div_clk[g];
              end else begin
                pf_cnt_q[g] <= pf_cnt_q[g] + 17'h1;
              end
            end
          end
        end
      end
    end
  endgenerate
  // ****************************************
  // Output banks and enables
  // ****************************************
  reg [7:0] src;
  reg [6:0] bank_d;
  integer b;
  always @* begin
    src = {cfg_image_data[0], int_div_clk, prec_div_clk, light_div_clk};
    bank_d = 7'h00;
    for (b = 0; b < 7; b = b + 1) begin
      case (bank_q[b*4 +: 3])
        3'h0: bank_d[b] = (b <= 1) ? src[0] : 1'b0;
        3'h1: bank_d[b] = (b <= 2) ? src[1] : 1'b0;
        3'h2: bank_d[b] = (b <= 3) ? src[2] : 1'b0;
        3'h3: bank_d[b] = src[3];
        3'h4: bank_d[b] = (b >= 3) ? src[4] : 1'b0;
        3'h5: bank_d[b] = (b >= 4) ? src[6] : 1'b0;
        3'h6: bank_d[b] = (b >= 5) ? src[5] : 1'b0;
        default: bank_d[b] = (b >= 5) ? src[7] : 1'b0;
      endcase
    end
  end
  wire [5:0] oe_pin_lvl;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_oep
      assign oe_pin_lvl[g] = oe_pin_q[g] ? gpio_in[oe_pin_q[6 + (g % 6)] ? g % 7 : (g + 1) % 7] : 1'b1;
    end
  endgenerate
  generate
    for (g = 0; g < N_OUT; g = g + 1) begin : g_oe
      always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          out_en[g] <= 1'b0;
        end else if (!bank_clk[g]) begin
          out_en[g] <= pu_done && oe_reg_q[g] && oe_pin_lvl[g % 6];
        end
      end
    end
  endgenerate
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_clk <= 7'h00;
      se_pin <= 2'b00;
    end else begin
      bank_clk <= pu_done ? bank_d : 7'h00;
      se_pin[0] <= se_q[0] & bank_d[0] & out_en[0];
      se_pin[1] <= se_q[1] & (se_q[2] ? ~bank_d[0] : bank_d[0]) & out_en[0];
    end
  end
endmodule // cgdc_top

// ===== verif/cgdc_i2c_host.sv
`timescale 1ns/1ns
module cgdc_i2c_host (
  input wire core_clk,
  input wire i2c_addr_hit,
  output logic [7:0] i2c_addr_match
);
  // ****************************************
  // Host address probe
  // ****************************************
  // Released bus shows the inverse address so a stale match cannot linger.
  initial i2c_addr_match = 8'h7f;
  task automatic probe(input logic [6:0] a, input int hold, output logic hit);
    @(posedge core_clk);
    i2c_addr_match <= {1'b0, a};
    repeat (hold) @(posedge core_clk);
    hit = i2c_addr_hit;
    i2c_addr_match <= {1'b1, ~a};
  endtask
endmodule // cgdc_i2c_host

// ===== verif/cgdc_props.sv
`timescale 1ns/1ns
module cgdc_props #(
  parameter N_OUT = 6
) (
  input wire core_clk,
  input wire arst_n,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire osc_ok,
  input wire pll_lock,
  input wire selftest_ok,
  input wire ref_over_limit,
  input wire ref_mon_active,
  input wire [6:0] gpio_out,
  input wire [6:0] gpio_oe,
  input wire [N_OUT-1:0] out_en
);
  // ****************************************
  // Power-up tracking and port properties
  // ****************************************
  // The tracker is sticky, so a later loss of lock never hides an early enable.
  reg up_q;
  reg fail_q;
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      up_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      if (osc_ok && pll_lock && selftest_ok && !fail_q) up_q <= 1'b1;
      if (osc_ok && !selftest_ok && !up_q) fail_q <= 1'b1;
    end
  end
  sequence s_wr_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arready && $past(s_axi_arvalid);
  endsequence
  property p_out_off;
    out_en != '0 |-> up_q;
  endproperty
  property p_fail_off;
    fail_q |-> out_en == '0;
  endproperty
  property p_bresp;
    s_wr_taken |-> ##2 s_axi_bvalid;
  endproperty
  property p_bonce;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_rdone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_rans;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  property p_apulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  property p_od;
    (gpio_oe[6:1] & gpio_out[6:1]) == 6'h00;
  endproperty
  property p_refmon;
    ref_over_limit [*2] |-> !ref_mon_active;
  endproperty
  a_out_off: assert property (p_out_off) else $error("outputs on before power-up");
  a_fail_off: assert property (p_fail_off) else $error("outputs on after failed power-up");
  a_bresp: assert property (p_bresp) else $error("no write response");
  a_bonce: assert property (p_bonce) else $error("write response repeated");
  a_rdone: assert property (p_rdone) else $error("read data repeated");
  a_rans: assert property (p_rans) else $error("no read data");
  a_apulse: assert property (p_apulse) else $error("awready held");
  a_od: assert property (p_od) else $error("open-drain pin driven high");
  a_refmon: assert property (p_refmon) else $error("monitor active above limit");
endmodule // cgdc_props
bind cgdc_top cgdc_props #(.N_OUT(N_OUT)) props_u (.*);

// ===== verif/testbench.sv
`timescale 1ns/1ns
`include "cgdc_consts.vh"
module testbench;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic osc_ok = 1'b0, pll_lock = 1'b0, selftest_ok = 1'b0, ref_over = 1'b0;
  logic [6:0] ext = 7'h7f;
  logic [1:0] gpi = 2'h0;
  wire awready, wready, bvalid, arready, rvalid, addr_hit, ref_mon;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [6:0] gpio_out, gpio_oe, gpio_in;
  wire [7:0] addr_match;
  wire [5:0] out_en;
  int bad_count = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  logic hit;
  // Wire level: driven pins show the design's value, others the board's.
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext);
  always #5 core_clk = ~core_clk;
  cgdc_top #(.SSC_TICK(16'h4)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cfg_image_sel(3'h5), .cfg_image_data(32'h0), .osc_ok(osc_ok), .pll_lock(pll_lock),
    .selftest_ok(selftest_ok), .ref_over_limit(ref_over), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .gpi_in(gpi), .i2c_addr_match(addr_match), .int_div_clk(),
    .light_div_clk(), .prec_div_clk(), .bank_clk(), .se_pin(), .out_en(out_en),
    .i2c_addr_hit(addr_hit), .ref_mon_active(ref_mon)
  );
  cgdc_i2c_host host_u (.core_clk(core_clk), .i2c_addr_hit(addr_hit), .i2c_addr_match(addr_match));
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    rs = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask
  task do_reset;
    arst_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_power;
    axi_wr(`CGDC_OFF_OE_CFG, 32'h3f);
    axi_rd(`CGDC_OFF_STATUS);
    chk(rd, 32'h0, "status early");
    chk({26'h0, out_en}, 32'h0, "outputs early");
    osc_ok <= 1'b1;
    pll_lock <= 1'b1;
    selftest_ok <= 1'b1;
    for (int i = 0; i < 50 && out_en !== 6'h3f; i++) @(posedge core_clk);
    chk({26'h0, out_en}, 32'h3f, "outputs on");
    axi_rd(`CGDC_OFF_STATUS);
    chk(rd, 32'h3, "status up");
    $display("test power done");
  endtask
  task t_regs;
    axi_rd(`CGDC_OFF_CTRL);
    chk(rd, {17'h0, `CGDC_RST_I2CADDR, 8'h00}, "ctrl reset");
    axi_rd(`CGDC_OFF_ID1);
    chk(rd, 32'h4, "ratio reset");
    axi_wr(`CGDC_OFF_ID0, 32'hffff_ffff);
    axi_rd(`CGDC_OFF_ID0);
    chk(rd, 32'h01ff_ffff, "ratio width");
    axi_wr(8'h3c, 32'h1);
    chk({30'h0, rs}, 32'h2, "unmapped write");
    axi_rd(8'h3c);
    chk({rs, rd[29:0]}, 32'h8000_0000, "unmapped read");
    $display("test regs done");
  endtask
  task t_i2c;
    host_u.probe(7'h09, 3, hit);
    chk({31'h0, hit}, 32'h1, "reset address");
    axi_wr(`CGDC_OFF_CTRL, 32'h2a00);
    host_u.probe(7'h09, 6, hit);
    chk({31'h0, hit}, 32'h0, "old address");
    host_u.probe(7'h2a, 3, hit);
    chk({31'h0, hit}, 32'h1, "new address");
    $display("test i2c done");
  endtask
  task t_gpio;
    ext <= 7'h7e;
    gpi <= 2'h2;
    axi_wr(`CGDC_OFF_GPIO_CFG, 32'h9);
    axi_wr(`CGDC_OFF_GPIO_OUT, 32'h1);
    axi_rd(`CGDC_OFF_GPIO_CFG);
    chk(rd, 32'h9, "gpio cfg");
    axi_rd(`CGDC_OFF_GPIO_IN);
    chk(rd, 32'h0002_0077, "gpio in");
    chk({25'h0, gpio_oe}, 32'h9, "gpio oe");
    chk({31'h0, gpio_out[0]}, 32'h1, "push pull");
    $display("test gpio done");
  endtask
  task t_refmon;
    axi_wr(`CGDC_OFF_CTRL, 32'h0001_0000);
    axi_rd(`CGDC_OFF_STATUS);
    chk(rd, 32'h103, "monitor on");
    chk({31'h0, ref_mon}, 32'h1, "monitor pin on");
    ref_over <= 1'b1;
    axi_rd(`CGDC_OFF_STATUS);
    chk(rd, 32'h3, "monitor off");
    chk({31'h0, ref_mon}, 32'h0, "monitor pin off");
    $display("test refmon done");
  endtask
  task t_fail;
    pll_lock <= 1'b0;
    axi_rd(`CGDC_OFF_STATUS);
    chk({31'h0, rd[0]}, 32'h0, "lock lost");
    pll_lock <= 1'b1;
    selftest_ok <= 1'b0;
    do_reset;
    axi_wr(`CGDC_OFF_OE_CFG, 32'h3f);
    repeat (30) @(posedge core_clk);
    chk({26'h0, out_en}, 32'h0, "outputs after fail");
    axi_rd(`CGDC_OFF_STATUS);
    chk({31'h0, rd[1]}, 32'h0, "done after fail");
    $display("test fail done");
  endtask
  initial begin
    do_reset;
    t_power;
    t_regs;
    t_i2c;
    t_gpio;
    t_refmon;
    t_fail;
    complete_run;
  end
  // The run needs fewer than two hundred cycles; 20000 cycles marks a hang.
  initial begin
    #200000;
    bad_count++;
    complete_run;
  end
endmodule // testbench
